/* File: bridge_pwm.sv */
// Enhanced bridge PWM output stage with shutdown and dead band
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "bridge_pwm_defs.svh"
`default_nettype none

module bridge_pwm
    import bridge_pwm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire timebase_t   tb,
    input  wire logic        int_pin_n,
    input  wire logic [1:0]  comparator_output,
    output logic             out_a,
    output logic             out_b,
    output logic             out_c,
    output logic             out_d,
    output logic             out_a_oe_n,
    output logic             out_b_oe_n,
    output logic             out_c_oe_n,
    output logic             out_d_oe_n
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ctrl_t      ctrl_q;
    sd_cfg_t    sd_q;
    db_ctl_t    db_q;
    dir_state_t state_q;
    logic        flag_q;
    logic        flag_d;
    logic        hold_q;
    logic        run_q;
    logic        dir_q;
    logic [1:0]  div_q;
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [3:0]  out_q;
    logic [3:0]  oe_n_q;
    logic [1:0]  db_out;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire acc     = psel & penable;
    wire done    = acc & pready_q;
    wire wr      = done & pwrite;
    wire hit_c   = paddr == `OFF_CTRL;
    wire hit_s   = paddr == `OFF_SDCFG;
    wire hit_d   = paddr == `OFF_DBCTL;
    wire hit_t   = paddr == `OFF_STATUS;
    wire mapped  = hit_c | hit_s | hit_d | hit_t;
    wire wr_sd   = wr & hit_s;
    wire [7:0] status = {4'h0, run_q, hold_q,
                         state_q == DIR_BLANK, dir_q};
    wire [7:0] rd_byte =
        hit_c ? ctrl_q :
        hit_s ? {flag_q, sd_q.src, sd_q.ac, sd_q.bd} :
        hit_d ? db_q :
        hit_t ? status : 8'h00;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire is_full   = ctrl_q.mode[0];
    wire is_half   = ctrl_q.mode == 2'b10;
    wire new_dir   = ctrl_q.mode[1];
    wire instr_en  = div_q == `INSTR_DIV;
    wire window    = tb.count == tb.period - `DIR_LEAD;
    wire pending   = is_full & (new_dir != dir_q);

    // ----------------------------------------
    // Shutdown sources, synchronised copies only
    // ----------------------------------------
    // source polarity
    wire [2:0] src_lvl = {~sync2_q[2], sync2_q[1:0]};
    wire src_hit = |(sd_q.src & src_lvl);
    wire shut    = flag_q | hold_q | src_hit;

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            prdata_q  <= {24'h00_0000, rd_byte};
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RST;
            sd_q   <= `SDCFG_RST;
            db_q   <= `DBCTL_RST;
        end else begin
            if (wr & hit_c)
                ctrl_q <= pwdata[7:0];
            if (wr_sd)
                sd_q <= pwdata[7:0];
            if (wr & hit_d)
                db_q <= pwdata[7:0];
        end
    end

    // Two-flop synchronisers for pin and comparator levels
    // sync before flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'b100;
            sync2_q <= 3'b100;
        end else begin
            sync1_q <= {int_pin_n, comparator_output};
            sync2_q <= sync1_q;
        end
    end

    // Instruction cycle enable, one in four clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end

    // ----------------------------------------
    // Shutdown event flag
    // ----------------------------------------
    // hardware set wins
    assign flag_d =
        src_hit                   ? 1'b1 :
        wr_sd                     ? pwdata[`SD_FLAG_BIT] :
        (db_q.restart & flag_q)   ? 1'b0 :
        flag_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    // Outputs stay parked until a period boundary
    // release at period start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hold_q <= 1'b0;
        else if (flag_q | src_hit)
            hold_q <= 1'b1;
        else if (tb.period_end)
            hold_q <= 1'b0;
    end

    // Start only on a whole period, avoids runt pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_q <= 1'b0;
        else if (!ctrl_q.en)
            run_q <= 1'b0;
        else if (tb.period_end)
            run_q <= 1'b1;
    end

    // ----------------------------------------
    // Direction sequencer
    // ----------------------------------------
    // change taken at window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DIR_STEADY;
            dir_q   <= 1'b0;
        end else begin
            case (state_q)
                DIR_STEADY: begin
                    if (!is_full) begin
                        dir_q <= new_dir;
                    end else if (pending & window) begin
                        dir_q   <= new_dir;
                        state_q <= DIR_BLANK;
                    end else if (pending & tb.period_end) begin
                        // Period too short for the lead
                        dir_q <= new_dir;
                    end
                end
                DIR_BLANK: begin
                    if (tb.period_end)
                        state_q <= DIR_STEADY;
                end
                default: state_q <= DIR_STEADY;
            endcase
        end
    end

    // ----------------------------------------
    // Half-bridge dead band, one counter per leg
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_db
            logic [6:0] cnt_q;
            // Leg A follows duty, leg B its complement
            // complementary legs
            wire tgt = run_q & is_half
                     & (gi == 0 ? tb.duty : ~tb.duty);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    cnt_q <= 7'h00;
                else if (!tgt)
                    cnt_q <= 7'h00;
                else if (instr_en & (cnt_q < db_q.count))
                    cnt_q <= cnt_q + 7'h01;
            end
            assign db_out[gi] = tgt & (cnt_q >= db_q.count);
        end
    endgenerate

    // ----------------------------------------
    // Output selection, order {d, c, b, a}
    // ----------------------------------------
    // blanking kills modulation
    wire mod = run_q & tb.duty & (state_q == DIR_STEADY);
    wire [3:0] nom =
        is_full ? (dir_q ? {1'b0, run_q, mod, 1'b0}
                         : {mod, 2'b00, run_q}) :
        is_half ? {2'b00, db_out} :
        {3'b000, run_q & tb.duty};
    wire [3:0] pin_en = !ctrl_q.en ? 4'h0 :
        is_full ? 4'hf : is_half ? 4'h3 : 4'h1;
    wire [3:0] sd_val = {sd_q.bd[0], sd_q.ac[0],
                         sd_q.bd[0], sd_q.ac[0]};
    wire [3:0] sd_tri = {sd_q.bd[1], sd_q.ac[1],
                         sd_q.bd[1], sd_q.ac[1]};

    // Registered pins; shutdown lags source by sync depth
    // force enabled pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q  <= 4'h0;
            oe_n_q <= 4'hf;
        end else begin
            out_q  <= shut ? sd_val : nom;
            oe_n_q <= ~pin_en | ({4{shut}} & sd_tri);
        end
    end

    // ----------------------------------------
    // Port drive
    // ----------------------------------------
    // flag visible in config read
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign out_a      = out_q[0];
    assign out_b      = out_q[1];
    assign out_c      = out_q[2];
    assign out_d      = out_q[3];
    assign out_a_oe_n = oe_n_q[0];
    assign out_b_oe_n = oe_n_q[1];
    assign out_c_oe_n = oe_n_q[2];
    assign out_d_oe_n = oe_n_q[3];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_cond;
        src_hit;
    endsequence

    sequence s_flag_up;
        flag_q;
    endsequence

    // Condition sets flag next edge
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        s_cond |=> s_flag_up;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set by condition");

    // Clear write refused while condition holds
    property p_wr_refused;
        @(posedge pclk) disable iff (!presetn)
        src_hit && wr_sd && !pwdata[7] |=> flag_q;
    endproperty
    a_wr_refused: assert property (p_wr_refused)
        else $error("flag cleared during condition");

    // Software write of one takes the flag
    property p_sw_shut;
        @(posedge pclk) disable iff (!presetn)
        wr_sd && pwdata[7] |=> flag_q ##1 shut;
    endproperty
    a_sw_shut: assert property (p_sw_shut)
        else $error("software shutdown lost");

    // Auto restart clears within one edge
    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        db_q.restart && flag_q && !src_hit && !wr_sd
        |=> !flag_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("auto restart failed");

    // Without auto restart the flag sticks
    property p_no_restart;
        @(posedge pclk) disable iff (!presetn)
        !db_q.restart && flag_q && !wr_sd |=> flag_q;
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("flag cleared without enable");

    // Parked outputs hold until period end
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        hold_q && !tb.period_end |=> hold_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("restart before period start");

    // Shutdown drives chosen AC pair level on A
    property p_pair;
        @(posedge pclk) disable iff (!presetn)
        shut && !sd_q.ac[1] |=> out_a == $past(sd_q.ac[0]);
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair AC level wrong");

    // Blank interval keeps B and D inactive
    property p_blank;
        @(posedge pclk) disable iff (!presetn)
        state_q == DIR_BLANK && !shut |=> !out_b && !out_d;
    endproperty
    a_blank: assert property (p_blank)
        else $error("modulated pin active in blank");

    // Pending change taken in window
    property p_window;
        @(posedge pclk) disable iff (!presetn)
        state_q == DIR_STEADY && pending && window
        |=> state_q == DIR_BLANK && dir_q == $past(new_dir);
    endproperty
    a_window: assert property (p_window)
        else $error("direction window missed");

    // Forward pattern on A and C
    property p_fwd;
        @(posedge pclk) disable iff (!presetn)
        is_full && !dir_q && run_q && !shut
        |=> out_a && !out_c;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward pattern wrong");

    // Dead band never lifts a low target
    property p_db;
        @(posedge pclk) disable iff (!presetn)
        is_half && !tb.duty && !shut |=> !out_a;
    endproperty
    a_db: assert property (p_db)
        else $error("leg A active without duty");

endmodule

`default_nettype wire

/* File: bridge_pwm_defs.svh */
// Offsets, field positions, reset values and timing counts
`ifndef BRIDGE_PWM_DEFS_SVH
`define BRIDGE_PWM_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL   12'h000
`define OFF_SDCFG  12'h004
`define OFF_DBCTL  12'h008
`define OFF_STATUS 12'h00c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SD_FLAG_BIT 7
`define CTRL_RST    8'h00
`define SDCFG_RST   8'h00
`define DBCTL_RST   8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DIR_LEAD    8'h04
`define INSTR_DIV   2'h3

`endif

/* File: bridge_pwm_pkg.sv */
// Types shared by the bridge PWM output stage
`default_nettype none

package bridge_pwm_pkg;

    // Mode/enable control, direction is mode[1]
    typedef struct packed {
        logic [4:0] rsvd;
        logic       en;
        logic [1:0] mode;
    } ctrl_t;

    // Shutdown configuration
    typedef struct packed {
        logic       flag;
        logic [2:0] src;
        logic [1:0] ac;
        logic [1:0] bd;
    } sd_cfg_t;

    // Dead-band control
    typedef struct packed {
        logic       restart;
        logic [6:0] count;
    } db_ctl_t;

    // Time base signals from the shared timer
    typedef struct packed {
        logic       period_end;
        logic       duty;
        logic [7:0] count;
        logic [7:0] period;
    } timebase_t;

    // Direction sequencer states
    typedef enum logic {
        DIR_STEADY,
        DIR_BLANK
    } dir_state_t;

endpackage

`default_nettype wire

/* File: bridge_load_model.sv */
// Power bridge model: resolves pin levels and watches for shoot-through
`timescale 1ns/1ps
`default_nettype none

module bridge_load_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] drv,
    input  wire logic [3:0] oe_n,
    output logic      [3:0] pin,
    output logic            shoot_seen
);
    // Gate pull-downs hold a released switch off, so no stale level remains
    assign pin = drv & ~oe_n;

    // Legs A/B and C/D: upper and lower switch on together is a short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shoot_seen <= 1'b0;
        end else if ((pin[0] & pin[1]) | (pin[2] & pin[3])) begin
            shoot_seen <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: bridge_pwm_shutdown_deadband_tb_top.sv */
// Self-checking bench for the bridge PWM output stage
`timescale 1ns/1ps
`include "bridge_pwm_defs.svh"
`default_nettype none

module bridge_pwm_shutdown_deadband_tb_top;
    import bridge_pwm_pkg::*;
    localparam logic [7:0] PER = 8'h27;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        int_pin_n;
    logic [1:0]  comparator_output;
    logic [3:0]  drv;
    logic [3:0]  oe_n;
    logic [3:0]  pin;
    logic        shoot_seen;
    logic [7:0]  cnt;
    logic [7:0]  duty_val;
    timebase_t   tbus;
    int          miscompares;
    int          compares;

    bridge_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tb(tbus),
        .int_pin_n(int_pin_n), .comparator_output(comparator_output), .out_a(drv[0]), .out_b(drv[1]),
        .out_c(drv[2]), .out_d(drv[3]), .out_a_oe_n(oe_n[0]), .out_b_oe_n(oe_n[1]), .out_c_oe_n(oe_n[2]),
        .out_d_oe_n(oe_n[3]));
    bridge_load_model load (.pclk(pclk), .presetn(presetn), .drv(drv), .oe_n(oe_n), .pin(pin),
        .shoot_seen(shoot_seen));

    // ----------------------------------------
    // Clock and shared time base
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Period of 40 counts; duty high while count is below duty_val
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= (cnt == PER) ? 8'h00 : cnt + 8'h01;
        end
    end
    assign tbus = '{period_end: (cnt == 8'h00), duty: (cnt < duty_val), count: cnt, period: PER};

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // One APB transfer; waits for pready, bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        // A slave that never answers is a failure, not a silent pass
        if (pready !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t bus answer timeout", $time);
        end
        r = prdata;
        chk({31'h0, pslverr}, {31'h0, a > `OFF_STATUS}, "pslverr wrong");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string m);
        logic [31:0] r;
        apb(1'b0, a, 8'h00, r);
        chk(r, {24'h00_0000, e}, m);
    endtask
    // Returns just after the edge at which the count was v
    task automatic at(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cnt !== v && n < 200);
        if (cnt !== v) begin
            miscompares++;
            $display("[ERR] %0t count wait timeout", $time);
        end
        #1;
    endtask
    task automatic pins(input logic [3:0] e, input string m);
        chk({28'h000_0000, pin}, {28'h000_0000, e}, m);
    endtask
    // Cycles from the duty rise to out_a going high
    task automatic rise(output int n);
        n = 0;
        at(PER);
        while (pin[0] !== 1'b1 && n < 100) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (pin[0] !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t rise wait timeout", $time);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(`OFF_CTRL, 8'h00, "ctrl reset");
        rd(`OFF_SDCFG, 8'h00, "sdcfg reset");
        rd(`OFF_DBCTL, 8'h00, "dbctl reset");
        rd(12'h010, 8'h00, "unmapped read");
    endtask
    // Near full duty so blanking shows; armed dead band must be ignored
    task automatic t_full;
        duty_val <= 8'd39;
        wr(`OFF_DBCTL, 8'h05);
        wr(`OFF_CTRL, 8'h05);
        at(8'h00);
        at(8'h02);
        pins(4'b1001, "forward drive");
        at(8'h05);
        wr(`OFF_CTRL, 8'h07);
        at(8'h1f);
        pins(4'b1001, "direction applied early");
        at(8'h25);
        pins(4'b0100, "direction window");
        at(8'h0a);
        pins(4'b0110, "reverse drive");
        rd(`OFF_STATUS, 8'h09, "status reverse");
    endtask
    task automatic t_pin_sd;
        wr(`OFF_SDCFG, 8'h46);
        rd(`OFF_SDCFG, 8'h46, "flag in normal run");
        int_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
        pins(4'b0101, "pair states");
        chk({28'h000_0000, oe_n}, 32'h0000_000a, "pair tristate");
        rd(`OFF_SDCFG, 8'hc6, "pin event flag");
        wr(`OFF_SDCFG, 8'h46);
        rd(`OFF_SDCFG, 8'hc6, "flag cleared while active");
        int_pin_n <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(`OFF_SDCFG, 8'hc6, "flag lost");
        at(8'h05);
        wr(`OFF_SDCFG, 8'h46);
        rd(`OFF_SDCFG, 8'h46, "flag clear");
        pins(4'b0101, "restart before period");
        rd(`OFF_STATUS, 8'h0d, "status parked");
        at(8'h0a);
        pins(4'b0110, "restart at period");
    endtask
    task automatic t_auto;
        wr(`OFF_DBCTL, 8'h80);
        wr(`OFF_SDCFG, 8'h10);
        comparator_output <= 2'b10;
        repeat (6) @(posedge pclk);
        rd(`OFF_SDCFG, 8'h10, "unselected source");
        comparator_output <= 2'b01;
        repeat (6) @(posedge pclk);
        rd(`OFF_SDCFG, 8'h90, "comparator event");
        pins(4'b0000, "pairs driven low");
        chk({28'h000_0000, oe_n}, 32'h0000_0000, "pairs driven");
        comparator_output <= 2'b00;
        repeat (6) @(posedge pclk);
        rd(`OFF_SDCFG, 8'h10, "auto clear");
        wr(`OFF_SDCFG, 8'h90);
        repeat (2) @(posedge pclk);
        rd(`OFF_SDCFG, 8'h10, "software with auto");
        wr(`OFF_DBCTL, 8'h00);
        wr(`OFF_SDCFG, 8'h84);
        rd(`OFF_SDCFG, 8'h84, "software shutdown");
        pins(4'b0101, "software park");
        wr(`OFF_SDCFG, 8'h04);
    endtask
    task automatic t_half;
        int  l0;
        int  l3;
        logic hi;
        hi = 1'b0;
        duty_val <= 8'd20;
        wr(`OFF_CTRL, 8'h06);
        at(8'h00);
        at(8'h0a);
        pins(4'b0001, "half bridge duty");
        at(8'h1e);
        pins(4'b0010, "half bridge complement");
        rise(l0);
        wr(`OFF_DBCTL, 8'h03);
        rise(l3);
        chk(32'(l3 - l0), 32'h0000_000c, "dead band length");
        at(8'h16);
        pins(4'b0000, "fall undelayed");
        wr(`OFF_DBCTL, 8'h7f);
        at(PER);
        repeat (80) begin
            @(posedge pclk);
            #1;
            hi = hi | pin[0];
        end
        chk({31'h0, hi}, 32'h0000_0000, "long dead band");
        chk({31'h0, shoot_seen}, 32'h0000_0000, "shoot-through");
        // Single mode: PWM on A only, dead band bypassed
        wr(`OFF_CTRL, 8'h04);
        at(8'h05);
        pins(4'b0001, "single duty");
        at(8'h1e);
        pins(4'b0000, "single low");
    endtask

    task automatic print_verdict;
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence, reset held for four cycles
    initial begin
        miscompares = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        int_pin_n = 1'b1;
        comparator_output = 2'b00;
        duty_val = 8'd20;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_full();
        t_pin_sd();
        t_auto();
        t_half();
        print_verdict();
    end
    // Run needs well under 1000 cycles; cut a hang at 20000
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
